// >>> common/mrf_defs.svh
// Address map, reset values, field positions and timing counts of the register file
`ifndef MRF_DEFS_SVH
`define MRF_DEFS_SVH

// Port data locations inside the register file
`define MRF_PORT0_ADDR 8'h00
`define MRF_PORT1_ADDR 8'h01
`define MRF_PORT2_ADDR 8'h02
`define MRF_PORT3_ADDR 8'h03
// General-purpose register span, 124 bytes
`define MRF_GPR_FIRST 8'h04
`define MRF_GPR_LAST 8'h7f
// Control and status block, 16 bytes, upper nibble f
`define MRF_CTRL_NIB 4'hf
`define MRF_P2M_ADDR 8'hf6
`define MRF_P3M_ADDR 8'hf7
`define MRF_P0M_ADDR 8'hf8
`define MRF_RP_ADDR 8'hfd
// Reset values of the configuration registers
`define MRF_P2M_RESET 8'hff
`define MRF_CTRL_RESET 8'h00
// Port 3 mode bits and port 3 line positions
`define MRF_P3M_HS_BIT 0
`define MRF_P3M_DMSEL_BIT 1
`define MRF_P3_STB_BIT 2
`define MRF_P3_DM_BIT 4
`define MRF_P3_RDY_BIT 5
`define MRF_P3_OE 8'hf0
// Data phase length of an external bus cycle, in clocks
`define MRF_DATA_CYCLES 2'h3

`endif

// >>> common/mrf_pkg.sv
// Types shared by the register file design
package mrf_pkg;
	// Port 0 function select
	typedef enum logic [1:0] {
		MRF_P0_IN = 2'b00,
		MRF_P0_OUT = 2'b01,
		MRF_P0_ADDR = 2'b10
	} mrf_p0_mode_e;
	// External bus cycle phases
	typedef enum logic [1:0] {
		MRF_BUS_IDLE = 2'b00,
		MRF_BUS_ADDR = 2'b01,
		MRF_BUS_DATA = 2'b10,
		MRF_BUS_DONE = 2'b11
	} mrf_bus_state_e;
endpackage

// >>> design/mrf_regfile.sv
// Register file, I/O ports and multiplexed external memory bus
`timescale 1ns/100ps
`default_nettype none
`include "mrf_defs.svh"

// Operation
// - Low address and data share one bus
// - Port 0 may drive address high byte
// - Separate 64K program and data spaces
// - 144-byte file: 124 GPR, 16 control, ports
// - Port 1 not usable as register
// - Any GPR usable as accumulator, pointer, stack
// - Nine groups of 16, pointer selects
// - Port 0 input, output or address; port 2 direction per bit
// - Ports carry status and handshake transfers
// - Port data mapped into register file
module mrf_regfile (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Register file access from the core
	input wire logic [7:0] rf_addr,
	input wire logic rf_short,
	input wire logic rf_wr,
	input wire logic rf_rd,
	input wire logic [7:0] rf_wdata,
	output logic [7:0] rf_rdata,
	output logic [7:0] rf_rp,
	// External memory request from the core
	input wire logic mem_req,
	input wire logic mem_wr,
	input wire logic mem_data_space,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	output logic mem_busy,
	output logic mem_done,
	output logic [7:0] mem_rdata,
	// Multiplexed address/data pins
	input wire logic [7:0] muxed_addr_data_low_in,
	output logic [7:0] muxed_addr_data_low_out,
	output logic [7:0] muxed_addr_data_low_oe,
	output logic addr_strobe_n,
	output logic data_strobe_n,
	output logic read_write,
	output logic data_mem_sel_n,
	// Port 0 pins
	input wire logic [7:0] p0_in,
	output logic [7:0] p0_out,
	output logic [7:0] p0_oe,
	// Port 2 pins
	input wire logic [7:0] p2_in,
	output logic [7:0] p2_out,
	output logic [7:0] p2_oe,
	// Port 3 pins
	input wire logic [7:0] p3_in,
	output logic [7:0] p3_out,
	output logic [7:0] p3_oe
);
	// GPR storage, indices 4 to 127 used
	logic [7:0] gpr_mem [0:127];
	// Control and status block
	logic [7:0] ctrl_mem [0:15];
	// Port output latches
	logic [7:0] p0_latch_reg;
	logic [7:0] p2_latch_reg;
	logic [7:0] p3_latch_reg;
	// Pin synchronisers, two stages each
	logic [7:0] p0_s1_reg, p0_s2_reg;
	logic [7:0] p2_s1_reg, p2_s2_reg;
	logic [7:0] p3_s1_reg, p3_s2_reg;
	logic [7:0] mad_s1_reg, mad_s2_reg;
	// Strobe history for edge detection
	logic stb_prev_reg;
	// Handshake capture of port 2
	logic [7:0] p2_cap_reg;
	logic p2_full_reg;
	// Bus cycle state
	mrf_pkg::mrf_bus_state_e bus_state_reg;
	logic [15:0] bus_addr_reg;
	logic bus_wr_reg;
	logic bus_space_reg;
	logic [7:0] bus_wdata_reg;
	logic [1:0] bus_cnt_reg;
	// Decoded configuration
	logic [7:0] p2m;
	logic [7:0] p3m;
	mrf_pkg::mrf_p0_mode_e p0m;
	logic [7:0] rp;
	logic [7:0] eff_addr;
	logic hs_on;
	logic stb_fall;
	logic p2_rd;
	logic [7:0] rd_next;
	logic [7:0] p2_view;

	// Configuration fields taken from the control block
	assign p2m = ctrl_mem[4'h6];
	assign p3m = ctrl_mem[4'h7];
	assign p0m = mrf_pkg::mrf_p0_mode_e'(ctrl_mem[4'h8][1:0]);
	assign rp = ctrl_mem[4'hd];
	assign hs_on = p3m[`MRF_P3M_HS_BIT];

	// Short references take the group from the pointer
	assign eff_addr = rf_short ? {rp[7:4], rf_addr[3:0]} : rf_addr;

	// Strobe edge seen only on the second stage
	assign stb_fall = stb_prev_reg & ~p3_s2_reg[`MRF_P3_STB_BIT];
	assign p2_rd = rf_rd && (eff_addr == `MRF_PORT2_ADDR);

	// Port 2 as seen by the core: inputs live or captured, outputs from latch
	assign p2_view = ((hs_on ? p2_cap_reg : p2_s2_reg) & p2m) | (p2_latch_reg & ~p2m);

	// Pin synchronisers
	always_ff @(posedge ref_clk) begin
		p0_s1_reg <= p0_in;
		p0_s2_reg <= p0_s1_reg;
		p2_s1_reg <= p2_in;
		p2_s2_reg <= p2_s1_reg;
		p3_s1_reg <= p3_in;
		p3_s2_reg <= p3_s1_reg;
		mad_s1_reg <= muxed_addr_data_low_in;
		mad_s2_reg <= mad_s1_reg;
	end

	// Read mux over the whole file
	always_comb begin
		rd_next = 8'h00;
		if (eff_addr == `MRF_PORT0_ADDR) begin
			// Output and address modes read the latch, both input codes read the pins
			rd_next = (p0m == mrf_pkg::MRF_P0_OUT || p0m == mrf_pkg::MRF_P0_ADDR) ?
				p0_latch_reg : p0_s2_reg;
		end else if (eff_addr == `MRF_PORT1_ADDR) begin
			// Bus port has no register behind it
			rd_next = 8'h00;
		end else if (eff_addr == `MRF_PORT2_ADDR) begin
			rd_next = p2_view;
		end else if (eff_addr == `MRF_PORT3_ADDR) begin
			rd_next = {p3_latch_reg[7:4], p3_s2_reg[3:0]};
		end else if (eff_addr <= `MRF_GPR_LAST) begin
			rd_next = gpr_mem[eff_addr[6:0]];
		end else if (eff_addr[7:4] == `MRF_CTRL_NIB) begin
			rd_next = ctrl_mem[eff_addr[3:0]];
		end else begin
			// Holes between the spans read as zero
			rd_next = 8'h00;
		end
	end

	// Read data register, updated only by reads
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rf_rdata <= 8'h00;
		end else if (rf_rd) begin
			rf_rdata <= rd_next;
		end
	end

	// GPR writes; RAM contents are not reset
	always_ff @(posedge ref_clk) begin
		if (rf_wr && eff_addr >= `MRF_GPR_FIRST && eff_addr <= `MRF_GPR_LAST) begin
			gpr_mem[eff_addr[6:0]] <= rf_wdata;
		end
	end

	// Control block writes
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			for (int i = 0; i < 16; i++) begin
				ctrl_mem[i] <= `MRF_CTRL_RESET;
			end
			// Port 2 comes up as input so nothing fights the pins
			ctrl_mem[4'h6] <= `MRF_P2M_RESET;
		end else if (rf_wr && eff_addr[7:4] == `MRF_CTRL_NIB) begin
			ctrl_mem[eff_addr[3:0]] <= rf_wdata;
		end
	end

	// Port output latches, written through the file
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			p0_latch_reg <= 8'h00;
			p2_latch_reg <= 8'h00;
			p3_latch_reg <= 8'h00;
		end else if (rf_wr) begin
			// Writes to port 1 fall through unused
			if (eff_addr == `MRF_PORT0_ADDR) begin
				p0_latch_reg <= rf_wdata;
			end
			if (eff_addr == `MRF_PORT2_ADDR) begin
				p2_latch_reg <= rf_wdata;
			end
			if (eff_addr == `MRF_PORT3_ADDR) begin
				p3_latch_reg <= rf_wdata;
			end
		end
	end

	// Input handshake on port 2; a new strobe beats the clearing read
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			stb_prev_reg <= 1'b1;
			p2_cap_reg <= 8'h00;
			p2_full_reg <= 1'b0;
		end else begin
			stb_prev_reg <= p3_s2_reg[`MRF_P3_STB_BIT];
			if (hs_on && stb_fall) begin
				p2_cap_reg <= p2_s2_reg;
				p2_full_reg <= 1'b1;
			end else if (p2_rd || !hs_on) begin
				p2_full_reg <= 1'b0;
			end
		end
	end

	// External bus cycle: address phase, then data phase
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			bus_state_reg <= mrf_pkg::MRF_BUS_IDLE;
			bus_addr_reg <= 16'h0000;
			bus_wr_reg <= 1'b0;
			bus_space_reg <= 1'b0;
			bus_wdata_reg <= 8'h00;
			bus_cnt_reg <= 2'h0;
			mem_busy <= 1'b0;
			mem_done <= 1'b0;
			mem_rdata <= 8'h00;
			muxed_addr_data_low_out <= 8'h00;
			muxed_addr_data_low_oe <= 8'h00;
			addr_strobe_n <= 1'b1;
			data_strobe_n <= 1'b1;
			read_write <= 1'b1;
			data_mem_sel_n <= 1'b1;
		end else begin
			mem_done <= 1'b0;
			case (bus_state_reg)
				mrf_pkg::MRF_BUS_IDLE: begin
					if (mem_req) begin
						// Latch the request; low byte goes out first
						bus_addr_reg <= mem_addr;
						bus_wr_reg <= mem_wr;
						bus_space_reg <= mem_data_space;
						bus_wdata_reg <= mem_wdata;
						mem_busy <= 1'b1;
						muxed_addr_data_low_out <= mem_addr[7:0];
						muxed_addr_data_low_oe <= 8'hff;
						addr_strobe_n <= 1'b0;
						read_write <= ~mem_wr;
						data_mem_sel_n <= ~mem_data_space;
						bus_state_reg <= mrf_pkg::MRF_BUS_ADDR;
					end
				end
				mrf_pkg::MRF_BUS_ADDR: begin
					// Same pins turn to data
					addr_strobe_n <= 1'b1;
					data_strobe_n <= 1'b0;
					muxed_addr_data_low_out <= bus_wdata_reg;
					muxed_addr_data_low_oe <= bus_wr_reg ? 8'hff : 8'h00;
					bus_cnt_reg <= `MRF_DATA_CYCLES;
					bus_state_reg <= mrf_pkg::MRF_BUS_DATA;
				end
				mrf_pkg::MRF_BUS_DATA: begin
					// Long enough for read data to clear the synchroniser
					bus_cnt_reg <= bus_cnt_reg - 2'h1;
					if (bus_cnt_reg == 2'h1) begin
						bus_state_reg <= mrf_pkg::MRF_BUS_DONE;
					end
				end
				mrf_pkg::MRF_BUS_DONE: begin
					if (!bus_wr_reg) begin
						mem_rdata <= mad_s2_reg;
					end
					data_strobe_n <= 1'b1;
					muxed_addr_data_low_oe <= 8'h00;
					read_write <= 1'b1;
					data_mem_sel_n <= 1'b1;
					mem_busy <= 1'b0;
					mem_done <= 1'b1;
					bus_state_reg <= mrf_pkg::MRF_BUS_IDLE;
				end
				default: begin
					bus_state_reg <= mrf_pkg::MRF_BUS_IDLE;
				end
			endcase
		end
	end

	// Port pin drivers, all from flops
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			p0_out <= 8'h00;
			p0_oe <= 8'h00;
			p2_out <= 8'h00;
			p2_oe <= 8'h00;
			p3_out <= 8'h00;
			p3_oe <= 8'h00;
			rf_rp <= 8'h00;
		end else begin
			rf_rp <= rp;
			case (p0m)
				mrf_pkg::MRF_P0_OUT: begin
					p0_out <= p0_latch_reg;
					p0_oe <= 8'hff;
				end
				mrf_pkg::MRF_P0_ADDR: begin
					// Holds the last high byte between cycles
					p0_out <= bus_addr_reg[15:8];
					p0_oe <= 8'hff;
				end
				default: begin
					p0_out <= 8'h00;
					p0_oe <= 8'h00;
				end
			endcase
			p2_out <= p2_latch_reg;
			p2_oe <= ~p2m;
			p3_oe <= `MRF_P3_OE;
			p3_out <= p3_latch_reg;
			// Status and handshake lines override the latch
			if (p3m[`MRF_P3M_DMSEL_BIT]) begin
				p3_out[`MRF_P3_DM_BIT] <= data_mem_sel_n;
			end
			if (hs_on) begin
				p3_out[`MRF_P3_RDY_BIT] <= ~p2_full_reg;
			end
		end
	end

	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	sequence s_bus_start;
		bus_state_reg == mrf_pkg::MRF_BUS_IDLE && mem_req;
	endsequence

	a_bus_addr_phase: assert property (s_bus_start |=>
		muxed_addr_data_low_oe == 8'hff && muxed_addr_data_low_out == $past(mem_addr[7:0])
		&& !addr_strobe_n ##1 addr_strobe_n && !data_strobe_n)
		else $error("Address phase wrong on muxed bus");
	a_high_byte_out: assert property (bus_state_reg == mrf_pkg::MRF_BUS_ADDR
		&& p0m == mrf_pkg::MRF_P0_ADDR |=> p0_out == bus_addr_reg[15:8] && p0_oe == 8'hff)
		else $error("High address byte not on port 0");
	a_space_select: assert property (s_bus_start |=>
		data_mem_sel_n == !$past(mem_data_space) ##1 data_mem_sel_n == $past(data_mem_sel_n))
		else $error("Space select wrong");
	a_hole_reads: assert property (rf_rd && eff_addr > `MRF_GPR_LAST
		&& eff_addr[7:4] != `MRF_CTRL_NIB |=> rf_rdata == 8'h00)
		else $error("Unmapped location read nonzero");
	a_port1_blank: assert property (rf_rd && eff_addr == `MRF_PORT1_ADDR
		|=> rf_rdata == 8'h00)
		else $error("Port 1 location returned data");
	a_short_long_same: assert property (rf_wr && rf_short
		&& eff_addr >= `MRF_GPR_FIRST && eff_addr <= `MRF_GPR_LAST
		##1 !rf_wr ##1 rf_rd && !rf_short && rf_addr == $past(eff_addr, 2)
		|=> rf_rdata == $past(rf_wdata, 3))
		else $error("Short write not seen by full read");
	a_dir_config: assert property (rf_wr && eff_addr == `MRF_P2M_ADDR
		|=> ##1 p2_oe == ~$past(rf_wdata, 2))
		else $error("Port 2 direction not applied");
	a_hs_ready: assert property (hs_on && stb_fall && !rf_wr
		|=> ##1 !p3_out[`MRF_P3_RDY_BIT])
		else $error("Ready not dropped after strobe");
	a_port_map: assert property (rf_wr && eff_addr == `MRF_PORT2_ADDR
		|=> ##1 p2_out == $past(rf_wdata, 2))
		else $error("Port 2 write not on pins");
endmodule // mrf_regfile
`default_nettype wire

// >>> test/mrf_ext_mem.sv
// External program and data memory on the multiplexed bus
`timescale 1ns/100ps
`default_nettype none
module mrf_ext_mem (
	// Clock
	input wire logic ref_clk,
	// Bus controls from the device
	input wire logic as_n,
	input wire logic ds_n,
	input wire logic rw,
	input wire logic dm_n,
	input wire logic [7:0] hi,
	// Multiplexed bus
	input wire logic [7:0] ad_out,
	input wire logic [7:0] ad_oe,
	output logic [7:0] ad_in
);
	logic [7:0] lo_reg; // Latched low address
	logic [7:0] last_reg; // Last level seen on the bus
	logic [7:0] dmem [logic [15:0]]; // Data space, filled by writes
	wire logic [15:0] a = {hi, lo_reg}; // Full address
	// A released bus shows the inverse of its last level, never a stale byte
	always @* begin
		if (!ds_n && rw)
			ad_in = dm_n ? (a[15:8] ^ a[7:0] ^ 8'h5a) : (dmem.exists(a) ? dmem[a] : 8'h00);
		else if (ad_oe == 8'hff)
			ad_in = ad_out;
		else
			ad_in = ~last_reg;
	end
	// Address latch and data-space write capture; program space is read only
	always @(posedge ref_clk) begin
		// Remember only driven levels so a released bus stays put
		if (ad_oe == 8'hff || (!ds_n && rw))
			last_reg <= ad_in;
		if (!as_n)
			lo_reg <= ad_out;
		if (!ds_n && !rw && !dm_n && ad_oe == 8'hff)
			dmem[a] = ad_out;
	end
endmodule // mrf_ext_mem
`default_nettype wire

// >>> test/mcu_register_file_and_ports_tb.sv
// Self-checking bench for the register file, ports and external bus
`timescale 1ns/100ps
`default_nettype none
module mcu_register_file_and_ports_tb;
	logic ref_clk = 1'b0; // 100 MHz clock
	logic sys_rst = 1'b1; // Synchronous reset
	logic [7:0] rf_addr = 8'h00, rf_wdata = 8'h00, p0_in = 8'h00, p2_in = 8'h00, p3_in = 8'h0f;
	logic rf_short = 1'b0, rf_wr = 1'b0, rf_rd = 1'b0; // Register strobes
	logic mem_req = 1'b0, mem_wr = 1'b0, mem_data_space = 1'b0; // Bus request
	logic [15:0] mem_addr = 16'h0000, a; // Bus address
	logic [7:0] mem_wdata = 8'h00, v, e; // Data and scratch
	logic [7:0] rsv [3] = '{8'h01, 8'h80, 8'hef}; // Refused locations
	wire logic [7:0] rf_rdata, rf_rp, mem_rdata, mad_in, mad_out, mad_oe;
	wire logic [7:0] p0_out, p0_oe, p2_out, p2_oe, p3_out, p3_oe;
	wire logic mem_busy, mem_done, as_n, ds_n, rw, dm_n;
	int miscompares = 0, cmp_count = 0, cycles = 0; // Counters
	logic [31:0] seed = 32'h0000005b; // Xorshift state
	mrf_regfile dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .rf_addr(rf_addr),
		.rf_short(rf_short), .rf_wr(rf_wr), .rf_rd(rf_rd), .rf_wdata(rf_wdata),
		.rf_rdata(rf_rdata), .rf_rp(rf_rp), .mem_req(mem_req), .mem_wr(mem_wr),
		.mem_data_space(mem_data_space), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_busy(mem_busy), .mem_done(mem_done), .mem_rdata(mem_rdata),
		.muxed_addr_data_low_in(mad_in), .muxed_addr_data_low_out(mad_out),
		.muxed_addr_data_low_oe(mad_oe), .addr_strobe_n(as_n), .data_strobe_n(ds_n),
		.read_write(rw), .data_mem_sel_n(dm_n), .p0_in(p0_in), .p0_out(p0_out),
		.p0_oe(p0_oe), .p2_in(p2_in), .p2_out(p2_out), .p2_oe(p2_oe), .p3_in(p3_in),
		.p3_out(p3_out), .p3_oe(p3_oe));
	mrf_ext_mem mem (.ref_clk(ref_clk), .as_n(as_n), .ds_n(ds_n), .rw(rw), .dm_n(dm_n),
		.hi(p0_out), .ad_out(mad_out), .ad_oe(mad_oe), .ad_in(mad_in));
	// Clock
	always #5 ref_clk = ~ref_clk;
	// Hang guard, far above the run length
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			test_done();
		end
	end
	// Xorshift source
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	// Verdict
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Compare one byte
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// Wait edges, then settle past the edge
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// Register write; idle cycle after so strobes never re-assert in one step
	task automatic wr(input logic [7:0] ad, input logic [7:0] d, input logic s);
		rf_addr = ad;
		rf_wdata = d;
		rf_short = s;
		rf_wr = 1'b1;
		tick(1);
		rf_wr = 1'b0;
		tick(1);
	endtask
	// Register read
	task automatic rd(input logic [7:0] ad, input logic s, output logic [7:0] d);
		rf_addr = ad;
		rf_short = s;
		rf_rd = 1'b1;
		tick(1);
		rf_rd = 1'b0;
		tick(1);
		d = rf_rdata;
	endtask
	// One external bus cycle, address and data phases checked as they stand
	task automatic mcyc(input logic w, input logic sp, input logic [15:0] ad,
		input logic [7:0] d, input logic [7:0] exp);
		int n;
		mem_wr = w;
		mem_data_space = sp;
		mem_addr = ad;
		mem_wdata = d;
		mem_req = 1'b1;
		tick(1);
		mem_req = 1'b0;
		chk({7'h00, as_n}, 8'h00);
		chk(mad_out, ad[7:0]);
		chk(mad_oe, 8'hff);
		chk({6'h00, mem_busy, rw}, {6'h00, 1'b1, ~w});
		chk({7'h00, dm_n}, {7'h00, ~sp});
		tick(1);
		chk({6'h00, as_n, ds_n}, 8'h02);
		chk(mad_oe, w ? 8'hff : 8'h00);
		if (w)
			chk(mad_out, d);
		chk({7'h00, p3_out[4]}, {7'h00, ~sp});
		n = 0;
		while (mem_done !== 1'b1 && n < 20) begin
			tick(1);
			n++;
		end
		chk({6'h00, mem_done, mem_busy}, 8'h02);
		chk(p0_out, ad[15:8]);
		if (!w)
			chk(mem_rdata, exp);
		tick(1);
	endtask
	// Main sequence
	initial begin
		tick(6);
		sys_rst = 1'b0;
		tick(1);
		chk({4'h0, as_n, ds_n, rw, dm_n}, 8'h0f);
		chk(p2_oe, 8'h00);
		chk(p3_oe, 8'hf0);
		// Random bytes through every general register
		for (int i = 4; i < 128; i++) begin
			v = rnd();
			wr(i[7:0], v, 1'b0);
			rd(i[7:0], 1'b0, e);
			chk(e, v);
		end
		// Port 1 slot and unmapped span read as zero
		for (int k = 0; k < 3; k++) begin
			wr(rsv[k], 8'ha5, 1'b0);
			rd(rsv[k], 1'b0, e);
			chk(e, 8'h00);
		end
		// Short references in each group
		for (int g = 0; g < 8; g++) begin
			wr(8'hfd, {g[3:0], 4'h0}, 1'b0);
			chk(rf_rp, {g[3:0], 4'h0});
			v = rnd();
			a[3:0] = v[3:0] | 4'h4;
			wr({4'h0, a[3:0]}, ~v, 1'b1);
			rd({g[3:0], a[3:0]}, 1'b0, e);
			chk(e, ~v);
		end
		wr(8'hfd, 8'hf0, 1'b0);
		rd(8'h0d, 1'b1, e);
		chk(e, 8'hf0);
		// Ports 2 and 0 as outputs through their locations
		wr(8'hf6, 8'h00, 1'b0);
		v = rnd();
		wr(8'h02, v, 1'b0);
		chk(p2_oe, 8'hff);
		chk(p2_out, v);
		wr(8'hf8, 8'h01, 1'b0);
		wr(8'h00, ~v, 1'b0);
		chk(p0_oe, 8'hff);
		chk(p0_out, ~v);
		// Port 0 back to input through the spare input code
		wr(8'hf8, 8'h03, 1'b0);
		chk(p0_oe, 8'h00);
		p0_in = v;
		tick(3);
		rd(8'h00, 1'b0, e);
		chk(e, v);
		p3_in = 8'h0d;
		tick(3);
		rd(8'h03, 1'b0, e);
		chk(e & 8'h0f, 8'h0d);
		// Port 2 input handshake, pins move after capture
		wr(8'hf6, 8'hff, 1'b0);
		wr(8'hf7, 8'h01, 1'b0);
		p2_in = v;
		tick(3);
		chk({7'h00, p3_out[5]}, 8'h01);
		p3_in = 8'h09;
		tick(4);
		p2_in = ~v;
		chk({7'h00, p3_out[5]}, 8'h00);
		rd(8'h02, 1'b0, e);
		chk(e, v);
		tick(2);
		chk({7'h00, p3_out[5]}, 8'h01);
		// Separate program and data spaces, 16-bit addresses, space select on port 3
		wr(8'hf8, 8'h02, 1'b0);
		wr(8'hf7, 8'h03, 1'b0);
		for (int i = 0; i < 4; i++) begin
			a = {rnd(), rnd()};
			v = rnd();
			mcyc(1'b1, 1'b1, a, v, 8'h00);
			mcyc(1'b0, 1'b0, a, 8'h00, a[15:8] ^ a[7:0] ^ 8'h5a);
			mcyc(1'b0, 1'b1, a, 8'h00, v);
		end
		test_done();
	end
endmodule // mcu_register_file_and_ports_tb
`default_nettype wire
